// ===== shared/sfc_pkg.sv
package sfc_pkg;

  // array address and clock-pulse counter widths
  localparam int ADDR_W = 15;
  localparam int CNT_W  = 16;

  // opcode table
  localparam logic [7:0] OPC_WR_EN       = 8'h06;
  localparam logic [7:0] OPC_WR_DIS      = 8'h04;
  localparam logic [7:0] OPC_ST_RD       = 8'h05;
  localparam logic [7:0] OPC_ST_WR       = 8'h01;
  localparam logic [7:0] OPC_RD          = 8'h03;
  localparam logic [7:0] OPC_FRD         = 8'h0B;
  localparam logic [7:0] OPC_DUAL_RD     = 8'h3B;
  localparam logic [7:0] OPC_PAGE_WR     = 8'h02;
  localparam logic [7:0] OPC_SECT_WIPE_A = 8'hD7;
  localparam logic [7:0] OPC_SECT_WIPE_B = 8'h20;
  localparam logic [7:0] OPC_BLK_WIPE    = 8'hD8;
  localparam logic [7:0] OPC_FULL_WIPE_A = 8'hC7;
  localparam logic [7:0] OPC_FULL_WIPE_B = 8'h60;
  localparam logic [7:0] OPC_SIG         = 8'hAB;
  localparam logic [7:0] OPC_STD_ID      = 8'h9F;
  localparam logic [7:0] OPC_MKR_ID      = 8'h90;

  // status register field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_WEL   = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 4;
  localparam int ST_LOCK  = 7;

  // values after reset
  localparam logic [2:0] BP_RST   = 3'h0;
  localparam logic       LOCK_RST = 1'b0;
  // idle levels of select, clock, data, protect and hold, in synchroniser order
  localparam logic [4:0] PIN_IDLE = 5'h13;

  // command lengths in bytes
  localparam logic [12:0] HDR_1B = 13'h0001;
  localparam logic [12:0] HDR_2B = 13'h0002;
  localparam logic [12:0] HDR_4B = 13'h0004;
  localparam logic [12:0] HDR_5B = 13'h0005;
  localparam logic [12:0] HDR_NONE = 13'h0000;

  // last bit index of an output byte, single and dual lane
  localparam logic [2:0] OUT_LAST_SGL = 3'h7;
  localparam logic [2:0] OUT_LAST_DUAL = 3'h3;

  typedef enum logic [1:0] {AOP_PROG, AOP_SECT, AOP_BLOCK, AOP_CHIP} sfc_arr_op_e;
  typedef enum logic [2:0] {PH_CMD, PH_HDR, PH_OUT, PH_DATA, PH_SKIP} sfc_phase_e;

  // header length of each command, zero for an unknown opcode
  function automatic logic [12:0] sfc_hdr_bytes(input logic [7:0] opc);
    case (opc)
      OPC_WR_EN, OPC_WR_DIS, OPC_ST_RD, OPC_STD_ID,
      OPC_FULL_WIPE_A, OPC_FULL_WIPE_B: sfc_hdr_bytes = HDR_1B;
      OPC_ST_WR:                        sfc_hdr_bytes = HDR_2B;
      OPC_SIG, OPC_MKR_ID, OPC_RD, OPC_PAGE_WR,
      OPC_SECT_WIPE_A, OPC_SECT_WIPE_B, OPC_BLK_WIPE: sfc_hdr_bytes = HDR_4B;
      OPC_FRD, OPC_DUAL_RD:             sfc_hdr_bytes = HDR_5B;
      default:                          sfc_hdr_bytes = HDR_NONE;
    endcase
  endfunction

  // commands that return data on the output line
  function automatic logic sfc_is_out(input logic [7:0] opc);
    case (opc)
      OPC_ST_RD, OPC_STD_ID, OPC_SIG, OPC_MKR_ID,
      OPC_RD, OPC_FRD, OPC_DUAL_RD: sfc_is_out = 1'b1;
      default:                      sfc_is_out = 1'b0;
    endcase
  endfunction

endpackage

// ===== rtl/sfc_sync.sv
`timescale 1ns/10ps

// two-flop synchroniser, one chain per bit
module sfc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // first stage is read only by the second
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          // reset to the pin's idle level, else a false edge follows reset
          meta_r[i] <= RST_VAL[i];
          q[i]      <= RST_VAL[i];
        end
        else
        begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule // sfc_sync

// ===== rtl/sfc_top.sv
`timescale 1ns/10ps

// Notes on behaviour
// - status bit 0 reads busy during writes
// - status bit 1 is volatile write enable
// - bits 2..4 hold block protect, reset zero
// - bit 7 is status lock flag
// - top protect bit only blocks chip wipe; 11 protects all
// - writes discarded unless pulses multiple of eight
// - status write refused only: lock and pin low
// - writes need write enable latch set first
// - input MSB first on rising clock edges
// - ABh signature and 90h ident, four bytes
// - 9Fh one byte, returns standard ident
// - 03h normal read, four bytes, 33 MHz
// - 0Bh fast read, five bytes, dummy byte
// - 3Bh fast read, two bits per clock
// - page write: four bytes plus 256 data
// - hold floats output and ignores input
// - signature: three dummies, then ident out
// - signature repeats until select rises
// - chip wipe only if all protect zero
// - latch clears after write and on disable
// - busy: only status read is decoded; status write still loads the last captured byte
// - modes 0 and 3: in rise, out fall
module sfc_top #(
  parameter logic [7:0] MAKER_ID1 = 8'h5A, // arbitrary value
  parameter logic [7:0] MAKER_ID2 = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID1   = 8'h11, // arbitrary value
  parameter logic [7:0] DEV_ID2   = 8'h22  // arbitrary value
) (
  input  wire logic                       CLK,
  input  wire logic                       RSTN,
  input  wire logic                       SEL_N,
  input  wire logic                       SCLK,
  input  wire logic                       SIO_I,
  output logic                            SIO_O,
  output logic                            SIO_OE_N,
  output logic                            SDO_O,
  output logic                            SDO_OE_N,
  input  wire logic                       WP_N,
  input  wire logic                       HOLD_N,
  output logic [sfc_pkg::ADDR_W-1:0]      ARR_ADDR,
  input  wire logic [7:0]                 ARR_RDATA,
  output logic [7:0]                      ARR_WDATA,
  output logic                            ARR_LOAD,
  output logic                            ARR_COMMIT,
  output sfc_pkg::sfc_arr_op_e            ARR_OP,
  input  wire logic                       ARR_DONE
);
  import sfc_pkg::*;

  logic                sel_n_s;
  logic                sclk_s;
  logic                sio_s;
  logic                wp_n_s;
  logic                hold_n_s;
  logic                sclk_q_r;
  logic                sel_q_r;
  logic                hold_r;
  logic                rise;
  logic                fall;
  logic                sel_rise;
  logic [CNT_W-1:0]    cnt_r;
  logic [12:0]         byte_idx;
  logic                byte_done;
  logic [7:0]          sr_in_r;
  logic [7:0]          sr_nxt;
  logic [7:0]          opc_r;
  sfc_phase_e          ph_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [7:0]          stat_new_r;
  logic                busy_r;
  logic                wel_r;
  logic [2:0]          bp_r;
  logic                lock_r;
  logic [7:0]          status;
  logic                prot_all;
  logic                len_ok;
  logic                st_writable;
  logic [7:0]          out_sr_r;
  logic [2:0]          out_bit_r;
  logic [1:0]          obyte_r;
  logic [7:0]          out_byte;
  logic                dual;
  logic                out_load;

  // pins from the master are asynchronous to CLK
  sfc_sync #(
    .W       (5),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .d     ({SEL_N, SCLK, SIO_I, WP_N, HOLD_N}),
    .q     ({sel_n_s, sclk_s, sio_s, wp_n_s, hold_n_s})
  );

  // delayed copies for edge detection
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sclk_q_r <= 1'b0;
      sel_q_r  <= 1'b1;
    end
    else
    begin
      sclk_q_r <= sclk_s;
      sel_q_r  <= sel_n_s;
    end
  end

  // hold follows the pin only while the clock is low, so a glitchy edge is not taken
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      hold_r <= 1'b0;
    else if (sel_n_s)
      hold_r <= 1'b0;
    else if (!sclk_s)
      hold_r <= !hold_n_s;
  end

  // clock edges count only while selected and not held
  assign rise      = sclk_s && !sclk_q_r && !sel_n_s && !hold_r;
  assign fall      = !sclk_s && sclk_q_r && !sel_n_s && !hold_r;
  assign sel_rise  = sel_n_s && !sel_q_r;
  assign byte_idx  = cnt_r[CNT_W-1:3];
  assign byte_done = rise && (cnt_r[2:0] == 3'h7);
  assign sr_nxt    = {sr_in_r[6:0], sio_s};

  // status image and protection decode
  assign status   = {lock_r, 2'b00, bp_r, wel_r, busy_r};
  assign prot_all = bp_r[1] && bp_r[0];
  assign len_ok   = (cnt_r[2:0] == 3'h0) && (byte_idx >= sfc_hdr_bytes(opc_r));
  assign st_writable = !(lock_r && !wp_n_s);

  // clock pulse counter and input shifter, cleared by deselect
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      cnt_r   <= '0;
      sr_in_r <= 8'h00;
    end
    else if (sel_n_s)
    begin
      cnt_r   <= '0;
      sr_in_r <= 8'h00;
    end
    else if (rise)
    begin
      cnt_r   <= cnt_r + 16'h0001;
      sr_in_r <= sr_nxt;
    end
  end

  // command phase sequencer
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ph_r  <= PH_CMD;
      opc_r <= 8'h00;
    end
    else if (sel_n_s)
      ph_r <= PH_CMD;
    else if (byte_done)
    begin
      case (ph_r)
        PH_CMD:
        begin
          opc_r <= sr_nxt;
          if (busy_r && sr_nxt != OPC_ST_RD)
            ph_r <= PH_SKIP;
          else if (sfc_hdr_bytes(sr_nxt) == HDR_NONE)
            ph_r <= PH_SKIP;
          else if (sfc_hdr_bytes(sr_nxt) == HDR_1B)
            ph_r <= sfc_is_out(sr_nxt) ? PH_OUT : PH_SKIP;
          else
            ph_r <= PH_HDR;
        end
        PH_HDR:
        begin
          if (byte_idx + 13'h0001 == sfc_hdr_bytes(opc_r))
          begin
            if (sfc_is_out(opc_r))
              ph_r <= PH_OUT;
            else if (opc_r == OPC_PAGE_WR)
              ph_r <= PH_DATA;
            else
              ph_r <= PH_SKIP;
          end
        end
        PH_OUT, PH_DATA, PH_SKIP: ph_r <= ph_r;
        default: ph_r <= PH_SKIP;
      endcase
    end
  end

  // address bytes and status write byte capture
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      addr_r     <= '0;
      stat_new_r <= 8'h00;
    end
    else if (byte_done && ph_r == PH_HDR)
    begin
      if (byte_idx <= 13'h0003)
        addr_r <= {addr_r[ADDR_W-9:0], sr_nxt};
      if (opc_r == OPC_ST_WR)
        stat_new_r <= sr_nxt;
    end
    else if (ARR_LOAD) // step after the load, so the array sees this byte's address
      addr_r[7:0] <= addr_r[7:0] + 8'h01;
    else if (out_load && sfc_hdr_bytes(opc_r) >= HDR_4B && opc_r != OPC_SIG
             && opc_r != OPC_MKR_ID)
      addr_r <= addr_r + 15'h0001;
  end

  // page data is handed to the array byte by byte
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ARR_LOAD  <= 1'b0;
      ARR_WDATA <= 8'h00;
    end
    else
    begin
      ARR_LOAD <= byte_done && ph_r == PH_DATA;
      if (byte_done && ph_r == PH_DATA)
        ARR_WDATA <= sr_nxt;
    end
  end

  // the array sees addr_r directly; reads look up combinationally
  assign ARR_ADDR = addr_r;

  // write enable latch; a set and a clear never meet in one cycle
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      wel_r <= 1'b0;
    else if (busy_r && ARR_DONE)
      wel_r <= 1'b0;
    else if (sel_rise && ph_r != PH_CMD && cnt_r == 16'h0008)
    begin
      if (opc_r == OPC_WR_EN && !busy_r)
        wel_r <= 1'b1;
      else if (opc_r == OPC_WR_DIS && !busy_r)
        wel_r <= 1'b0;
    end
    else if (sel_rise && opc_r == OPC_ST_WR && ph_r == PH_SKIP && wel_r && len_ok
             && cnt_r == 16'h0010 && st_writable)
      wel_r <= 1'b0;
  end

  // status write; completes at once, so the busy bit never rises for it
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      bp_r   <= BP_RST;
      lock_r <= LOCK_RST;
    end
    else if (sel_rise && opc_r == OPC_ST_WR && ph_r == PH_SKIP && wel_r && len_ok
             && cnt_r == 16'h0010 && st_writable)
    begin
      bp_r   <= stat_new_r[ST_BP_HI:ST_BP_LO];
      lock_r <= stat_new_r[ST_LOCK];
    end
  end

  // program and erase launch at deselect; busy holds until the array is done
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      busy_r     <= 1'b0;
      ARR_COMMIT <= 1'b0;
      ARR_OP     <= AOP_PROG;
    end
    else
    begin
      ARR_COMMIT <= 1'b0;
      if (busy_r && ARR_DONE)
        busy_r <= 1'b0;
      else if (sel_rise && wel_r && len_ok && !busy_r && ph_r != PH_CMD)
      begin
        case (opc_r)
          OPC_PAGE_WR:
          begin
            if (!prot_all && ph_r == PH_DATA && byte_idx > HDR_4B)
            begin
              busy_r     <= 1'b1;
              ARR_COMMIT <= 1'b1;
              ARR_OP     <= AOP_PROG;
            end
          end
          OPC_SECT_WIPE_A, OPC_SECT_WIPE_B, OPC_BLK_WIPE:
          begin
            if (!prot_all && byte_idx == HDR_4B)
            begin
              busy_r     <= 1'b1;
              ARR_COMMIT <= 1'b1;
              ARR_OP     <= (opc_r == OPC_BLK_WIPE) ? AOP_BLOCK : AOP_SECT;
            end
          end
          OPC_FULL_WIPE_A, OPC_FULL_WIPE_B:
          begin
            if (bp_r == 3'h0 && byte_idx == HDR_1B)
            begin
              busy_r     <= 1'b1;
              ARR_COMMIT <= 1'b1;
              ARR_OP     <= AOP_CHIP;
            end
          end
          default: busy_r <= busy_r;
        endcase
      end
    end
  end

  // next byte to send, chosen by the command and the output byte count
  always_comb
  begin
    out_byte = 8'h00;
    case (opc_r)
      OPC_ST_RD: out_byte = status;
      OPC_SIG:   out_byte = DEV_ID1;
      OPC_STD_ID:
        case (obyte_r)
          2'h0:    out_byte = MAKER_ID2;
          2'h1:    out_byte = MAKER_ID1;
          default: out_byte = DEV_ID2;
        endcase
      OPC_MKR_ID: out_byte = (obyte_r[0] ^ addr_r[0]) ? DEV_ID1 : MAKER_ID1;
      default:   out_byte = ARR_RDATA;
    endcase
  end

  assign dual     = (opc_r == OPC_DUAL_RD);
  assign out_load = fall && ph_r == PH_OUT && out_bit_r == 3'h0;

  // output shifter: new byte on the first falling edge of each byte
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      out_sr_r  <= 8'h00;
      out_bit_r <= 3'h0;
      obyte_r   <= 2'h0;
      SDO_O     <= 1'b0;
      SIO_O     <= 1'b0;
    end
    else if (ph_r != PH_OUT)
    begin
      out_bit_r <= 3'h0;
      obyte_r   <= 2'h0;
    end
    else if (fall)
    begin
      if (out_bit_r == 3'h0)
      begin
        SDO_O     <= out_byte[7];
        SIO_O     <= out_byte[6];
        out_sr_r  <= dual ? {out_byte[5:0], 2'b00} : {out_byte[6:0], 1'b0};
        out_bit_r <= dual ? OUT_LAST_DUAL : OUT_LAST_SGL;
        obyte_r   <= (opc_r == OPC_STD_ID && obyte_r == 2'h2) ? 2'h0 : obyte_r + 2'h1;
      end
      else
      begin
        SDO_O     <= out_sr_r[7];
        SIO_O     <= out_sr_r[6];
        out_sr_r  <= dual ? {out_sr_r[5:0], 2'b00} : {out_sr_r[6:0], 1'b0};
        out_bit_r <= out_bit_r - 3'h1;
      end
    end
  end

  // drivers float when deselected or held; the input line turns round for dual
  assign SDO_OE_N = !(ph_r == PH_OUT && !sel_n_s && !hold_r);
  assign SIO_OE_N = !(ph_r == PH_OUT && dual && !sel_n_s && !hold_r);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_busy_commit: assert property (ARR_COMMIT |-> busy_r && status[ST_BUSY])
    else $error("busy not set with array commit");
  a_wel_done_clr: assert property (busy_r && ARR_DONE |=> !wel_r && !busy_r)
    else $error("write enable latch kept after write done");
  a_commit_wel: assert property (ARR_COMMIT |-> $past(wel_r))
    else $error("array commit without write enable");
  a_commit_len: assert property (ARR_COMMIT |-> $past(cnt_r[2:0]) == 3'h0)
    else $error("array commit after partial byte");
  a_chip_unprot: assert property (ARR_COMMIT && ARR_OP == AOP_CHIP |-> bp_r == 3'h0)
    else $error("chip wipe while protected");
  a_prot_block: assert property (ARR_COMMIT && ARR_OP != AOP_CHIP |-> !$past(prot_all))
    else $error("write into protected array");
  a_lock_hold: assert property ($changed({lock_r, bp_r}) |->
                                !($past(lock_r) && !$past(wp_n_s)))
    else $error("status changed while locked");
  a_hold_float: assert property (hold_r |-> SDO_OE_N && SIO_OE_N ##1 !rise)
    else $error("output driven during hold");
  a_busy_skip: assert property (busy_r && ph_r == PH_CMD && byte_done
                                && sr_nxt != OPC_ST_RD |=> ph_r == PH_SKIP)
    else $error("command accepted while busy");
  a_opc_capture: assert property (byte_done && ph_r == PH_CMD |=> opc_r == $past(sr_nxt))
    else $error("opcode not captured");

endmodule // sfc_top

// ===== testbench/sfc_spi_master.sv
`timescale 1ns/10ps

// link master model; half period of four system clocks, modes 0 and 3
module sfc_spi_master (
  input  wire logic CLK,
  input  wire logic SDO_O,
  input  wire logic SIO_O,
  input  wire logic SDO_OE_N,
  output logic      SEL_N,
  output logic      SCLK,
  output logic      SIO_M,
  output logic      HOLD_N
);
  logic       mode3   = 1'b0;
  int         hold_at = -1;
  int         nb;
  logic       hold_oe;
  logic [7:0] rx;
  event       got;

  // idle: deselected, clock at rest, hold released
  initial
  begin
    SEL_N  = 1'b1;
    SCLK   = 1'b0;
    SIO_M  = 1'b0;
    HOLD_N = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic set_mode(input logic m);
    mode3 = m;
    SCLK  = m;
    tick(4);
  endtask

  // clock and data keep moving while held, so a leaky hold shows up
  task automatic pause();
    SCLK = 1'b0;
    tick(4);
    HOLD_N = 1'b0;
    tick(4);
    repeat (8)
    begin
      SCLK  = ~SCLK;
      SIO_M = 1'($urandom);
      tick(4);
    end
    hold_oe = SDO_OE_N;
    HOLD_N  = 1'b1;
    tick(4);
  endtask

  // fall and drive, sample late in the low phase, then rise
  task automatic bit_x(input logic d, output logic [1:0] s);
    if (nb == hold_at)
      pause();
    nb++;
    SCLK  = 1'b0;
    SIO_M = d;
    tick(4);
    s    = {SDO_O, SIO_O};
    SCLK = 1'b1;
    tick(4);
  endtask

  // one command: nbits from the top of tx, then nrd bytes read back
  task automatic send(input logic [63:0] tx, input int nbits, input int nrd,
                      input logic dual);
    logic [1:0] s;
    nb    = 0;
    SEL_N = 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++)
      bit_x(tx[63-i], s);
    for (int k = 0; k < nrd; k++)
    begin
      for (int j = 0; j < (dual ? 4 : 8); j++)
      begin
        bit_x(~SIO_M, s);
        rx = dual ? {rx[5:0], s} : {rx[6:0], s[1]};
      end
      -> got;
    end
    if (!mode3)
      SCLK = 1'b0;
    tick(4);
    SEL_N   = 1'b1;
    SIO_M   = ~SIO_M;
    hold_at = -1;
    tick(4);
  endtask
endmodule // sfc_spi_master

// ===== testbench/sfc_top_tb.sv
`timescale 1ns/10ps

module sfc_top_tb;
  import sfc_pkg::*;

  // identity values are arbitrary
  localparam logic [7:0]  MK1 = 8'h5A;
  localparam logic [7:0]  MK2 = 8'h3C;
  localparam logic [7:0]  DV1 = 8'h11;
  localparam logic [7:0]  DV2 = 8'h22;
  localparam logic [7:0]  WIPE_OPC [5] = '{OPC_SECT_WIPE_A, OPC_SECT_WIPE_B, OPC_BLK_WIPE,
                                           OPC_FULL_WIPE_A, OPC_FULL_WIPE_B};
  localparam sfc_arr_op_e WIPE_OP [5] = '{AOP_SECT, AOP_SECT, AOP_BLOCK, AOP_CHIP, AOP_CHIP};
  localparam int          WIPE_BITS [5] = '{32, 32, 32, 8, 8};
  localparam logic [7:0]  RD_OPC [3] = '{OPC_RD, OPC_FRD, OPC_DUAL_RD};

  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              wp_n = 1'b1;
  logic              sel_n, sclk, sio_m, hold_n, sio_o, sio_oe_n, sdo_o, sdo_oe_n;
  logic [ADDR_W-1:0] arr_addr;
  logic [7:0]        arr_wdata;
  logic              arr_load, arr_commit;
  sfc_arr_op_e       arr_op;
  logic              arr_done = 1'b0;
  logic              pend = 1'b0;
  logic              go = 1'b0;
  logic              exp_dual = 1'b0;
  int                failures = 0;
  int                n_compared = 0;
  logic [7:0]        q_rd [$];
  logic [22:0]       q_ld [$];
  sfc_arr_op_e       q_op [$];
  wire logic         sio_i = sio_oe_n ? sio_m : sio_o;
  wire logic [7:0]   arr_rdata = arr_addr[7:0] ^ 8'h5A;

  always #12.5 clk = ~clk;

  sfc_top u_dut (
    .CLK(clk), .RSTN(rstn), .SEL_N(sel_n), .SCLK(sclk), .SIO_I(sio_i), .SIO_O(sio_o),
    .SIO_OE_N(sio_oe_n), .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .WP_N(wp_n), .HOLD_N(hold_n),
    .ARR_ADDR(arr_addr), .ARR_RDATA(arr_rdata), .ARR_WDATA(arr_wdata), .ARR_LOAD(arr_load),
    .ARR_COMMIT(arr_commit), .ARR_OP(arr_op), .ARR_DONE(arr_done));

  sfc_spi_master u_m (
    .CLK(clk), .SDO_O(sdo_o), .SIO_O(sio_o), .SDO_OE_N(sdo_oe_n), .SEL_N(sel_n),
    .SCLK(sclk), .SIO_M(sio_m), .HOLD_N(hold_n));

  function automatic logic [7:0] mem(input logic [14:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // serial results against the oldest note
  always @(u_m.got)
  begin
    if (q_rd.size() == 0)
      chk("read unexpected", 23'h0, 23'h1);
    else
      chk("read byte", 23'(q_rd.pop_front()), 23'(u_m.rx));
    chk("drive enables", 23'({1'b0, !exp_dual}), 23'({sdo_oe_n, sio_oe_n}));
  end

  // array requests against the notes; anything unasked for is a fault
  always @(posedge clk)
  begin
    if (arr_load === 1'b1)
      chk("array load", q_ld.size() ? q_ld.pop_front() : 23'h7FFFFF, {arr_addr, arr_wdata});
    if (arr_commit === 1'b1)
      chk("array op", q_op.size() ? 23'(q_op.pop_front()) : 23'h7FFFFF, 23'(arr_op));
  end

  // array finishes only when released, so busy can be watched
  always @(negedge clk)
  begin
    arr_done <= pend && go;
    if (arr_commit === 1'b1)
      pend <= 1'b1;
    else if (pend && go)
      pend <= 1'b0;
  end

  task automatic cmd(input logic [63:0] tx, input int n);
    u_m.send(tx, n, 0, 1'b0);
  endtask

  task automatic write_enable_cmd();
    cmd({OPC_WR_EN, 56'h0}, 8);
  endtask

  task automatic st(input logic [7:0] v);
    q_rd.push_back(v);
    q_rd.push_back(v);
    u_m.send({OPC_ST_RD, 56'h0}, 8, 2, 1'b0);
  endtask

  task automatic page(input logic ok);
    logic [14:0] a;
    logic [23:0] d;
    a = 15'($urandom);
    d = 24'($urandom);
    // data bytes reach the array even when protection later refuses the commit
    for (int i = 0; i < 3; i++)
      q_ld.push_back({a[14:8], a[7:0] + 8'(i), d[23-8*i -: 8]});
    if (ok)
      q_op.push_back(AOP_PROG);
    cmd({OPC_PAGE_WR, 9'h0, a, d, 8'h0}, 56);
  endtask

  task automatic finish_op();
    u_m.tick(8);
    go = 1'b1;
    for (int i = 0; i < 100 && pend; i++)
      u_m.tick(1);
    go = 1'b0;
    if (pend)
    begin
      failures++;
      $display("FAIL array done expected 0 seen 1");
      end_of_test();
    end
  endtask

  initial
  begin
    logic [14:0] a;
    void'($urandom(32'hDE96));
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    u_m.tick(4);
    st(8'h00);
    write_enable_cmd();
    st(8'h02);
    cmd({OPC_WR_DIS, 56'h0}, 8);
    st(8'h00);
    u_m.hold_at = 4;
    write_enable_cmd();
    st(8'h02);
    u_m.hold_at = 12;
    st(8'h02);
    chk("hold float", 23'h1, 23'(u_m.hold_oe));
    u_m.set_mode(1'b1);
    st(8'h02);
    u_m.set_mode(1'b0);
    cmd({OPC_ST_WR, 8'hFC, 48'h0}, 16);
    st(8'h9C);
    wp_n = 1'b0;
    write_enable_cmd();
    cmd({OPC_ST_WR, 8'h00, 48'h0}, 16);
    st(8'h9E);
    wp_n = 1'b1;
    cmd({OPC_ST_WR, 8'h0C, 48'h0}, 16);
    st(8'h0C);
    write_enable_cmd();
    page(1'b0);
    cmd({OPC_FULL_WIPE_A, 56'h0}, 8);
    st(8'h0E);
    cmd({OPC_ST_WR, 8'h10, 48'h0}, 16);
    write_enable_cmd();
    page(1'b1);
    st(8'h13);
    cmd({OPC_WR_DIS, 56'h0}, 8);
    st(8'h13);
    finish_op();
    st(8'h10);
    write_enable_cmd();
    cmd({OPC_FULL_WIPE_B, 56'h0}, 8);
    wp_n = 1'b0;
    cmd({OPC_ST_WR, 8'h00, 48'h0}, 16);
    wp_n = 1'b1;
    st(8'h00);
    cmd({OPC_SECT_WIPE_A, 56'h0}, 32);
    write_enable_cmd();
    cmd({OPC_SECT_WIPE_A, 56'h0}, 31);
    for (int i = 0; i < 5; i++)
    begin
      write_enable_cmd();
      q_op.push_back(WIPE_OP[i]);
      cmd({WIPE_OPC[i], 56'h0}, WIPE_BITS[i]);
      finish_op();
    end
    st(8'h00);
    for (int m = 0; m < 3; m++)
    begin
      a = 15'($urandom);
      exp_dual = (m == 2);
      q_rd.push_back(mem(a));
      q_rd.push_back(mem(a + 15'h1));
      u_m.send({RD_OPC[m], 9'h0, a, 32'h0}, m == 0 ? 32 : 40, 2, m == 2);
    end
    exp_dual = 1'b0;
    q_rd = '{MK2, MK1, DV2, MK2};
    u_m.send({OPC_STD_ID, 56'h0}, 8, 4, 1'b0);
    q_rd = '{DV1, DV1, DV1};
    u_m.send({OPC_SIG, 56'h0}, 32, 3, 1'b0);
    q_rd = '{MK1, DV1, MK1};
    u_m.send({OPC_MKR_ID, 56'h0}, 32, 3, 1'b0);
    q_rd = '{DV1, MK1};
    u_m.send({OPC_MKR_ID, 24'h1, 32'h0}, 32, 2, 1'b0);
    u_m.tick(20);
    chk("notes left", 23'h0, 23'(q_rd.size() + q_ld.size() + q_op.size()));
    end_of_test();
  end
endmodule // sfc_top_tb
